// ===== pkg/ioexp_pkg.sv
// shared constants, types and carriers of the serial port expander
package ioexp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned PORT_W     = 8;
  localparam int unsigned ADDR_SEL_W = 3;
  localparam int unsigned ADDR_FIX_W = 4;
  localparam int unsigned BIT_CNT_W  = 3;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [PORT_W-1:0]    PORT_RST     = 8'hFF;  // lines high at power on
  localparam logic [BIT_CNT_W-1:0] BIT_LAST     = 3'h7;   // eighth bit of a byte
  localparam logic [BIT_CNT_W-1:0] BIT_FIRST    = 3'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_ONE      = 3'h1;
  localparam logic [ADDR_FIX_W-1:0] ADDR_FIX_DEF = 4'h4;  // arbitrary neutral value

  // ----------------------------------------------------------------
  // serial link states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LNK_IDLE,
    LNK_ADDR,
    LNK_ADDR_ACK,
    LNK_WR_DATA,
    LNK_WR_ACK,
    LNK_RD_DATA,
    LNK_RD_ACK
  } ioexp_link_st_t;

  // ----------------------------------------------------------------
  // words carried from the link domain into the system domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PORT_W-1:0] pins;   // raw port line levels
    logic [PORT_W-1:0] latch;  // output latch, quasi-static
    logic              rd_clr; // toggle per read acknowledge
    logic              wr_clr; // toggle per write acknowledge
  } ioexp_cross_t;

  localparam int unsigned CROSS_W = $bits(ioexp_cross_t);

endpackage : ioexp_pkg

// ===== design/ioexp_sync.sv
// two flip-flop level synchroniser of parameterised width
`timescale 1ns/10ps

module ioexp_sync
  import ioexp_pkg::*;
#(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // ----------------------------------------------------------------
  // the first stage feeds the second stage only
  // ----------------------------------------------------------------
  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;

endmodule // ioexp_sync

// ===== design/ioexp_irq.sv
// interrupt detector for port line changes, system clock domain
`timescale 1ns/10ps

module ioexp_irq
  import ioexp_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  input  wire logic [PORT_W-1:0] pins_i,
  input  wire logic [PORT_W-1:0] latch_i,
  input  wire logic [1:0]        clr_tog_i,
  output logic                   irq_pend_o
);

  logic [PORT_W-1:0] snap_q;
  logic [PORT_W-1:0] snap_d;
  logic [1:0]        clr_seen_q;
  logic [1:0]        clr_seen_d;
  logic              pend_q;
  logic              pend_d;
  logic              clr_evt;

  // ----------------------------------------------------------------
  // snapshot re-arm and change compare
  // ----------------------------------------------------------------
  // only lines whose latch is high act as inputs; a low line is held
  // low by the device and can never produce an edge of its own
  always_comb begin
    clr_evt    = |(clr_tog_i ^ clr_seen_q);
    clr_seen_d = clr_tog_i;
    snap_d     = clr_evt ? pins_i : snap_q;
    pend_d     = |((pins_i ^ snap_d) & latch_i);
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      snap_q     <= PORT_RST;
      clr_seen_q <= 2'h0;
      pend_q     <= 1'b0;
    end else begin
      snap_q     <= snap_d;
      clr_seen_q <= clr_seen_d;
      pend_q     <= pend_d;
    end
  end

  assign irq_pend_o = pend_q;

endmodule // ioexp_irq

// ===== design/ioexp_top.sv
// serial slave of the 8-bit quasi-bidirectional port expander
`timescale 1ns/10ps

module ioexp_top
  import ioexp_pkg::*;
#(
  parameter logic [ADDR_FIX_W-1:0] ADDR_FIX = ADDR_FIX_DEF
) (
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  input  wire logic              scl_clk_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  input  wire logic              addr_select_pin_0_i,
  input  wire logic              addr_select_pin_1_i,
  input  wire logic              addr_select_pin_2_i,
  input  wire logic [PORT_W-1:0] port_line_i,
  output logic      [PORT_W-1:0] port_line_o,
  output logic      [PORT_W-1:0] port_line_oe_o,
  output logic                   irq_n_o,
  output logic                   irq_n_oe_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int unsigned LSYNC_W = PORT_W + ADDR_SEL_W;

  // start / stop toggles, clocked by the data line
  logic start_tog_q;
  logic start_tog_d;
  logic stop_tog_q;
  logic stop_tog_d;

  // receive group, rising clock edge
  ioexp_link_st_t       state_q;
  ioexp_link_st_t       state_d;
  logic [PORT_W-1:0]    shift_q;
  logic [PORT_W-1:0]    shift_d;
  logic [BIT_CNT_W-1:0] cnt_q;
  logic [BIT_CNT_W-1:0] cnt_d;
  logic                 start_seen_q;
  logic                 start_seen_d;
  logic                 stop_seen_q;
  logic                 stop_seen_d;
  logic                 wr_commit_q;
  logic                 wr_commit_d;
  logic                 rd_clr_q;
  logic                 rd_clr_d;

  // transmit group, falling clock edge
  logic                 drive_q;
  logic                 drive_d;
  logic [PORT_W-1:0]    tx_q;
  logic [PORT_W-1:0]    tx_d;
  logic [PORT_W-1:0]    latch_q;
  logic [PORT_W-1:0]    latch_d;
  logic [PORT_W-1:0]    strong_q;
  logic [PORT_W-1:0]    strong_d;
  logic [PORT_W-1:0]    pout_q;
  logic [PORT_W-1:0]    pout_d;
  logic [PORT_W-1:0]    poe_q;
  logic [PORT_W-1:0]    poe_d;
  logic                 wr_clr_q;
  logic                 wr_clr_d;

  // synchronised views
  logic [LSYNC_W-1:0]   lnk_sync;
  logic [PORT_W-1:0]    lnk_pins;
  logic [ADDR_SEL_W-1:0] lnk_sel;
  ioexp_cross_t         cross_raw;
  ioexp_cross_t         cross_sync;
  logic                 irq_pend;

  logic                 start_pend;
  logic                 stop_pend;
  logic [PORT_W-1:0]    rx_byte;
  logic                 addr_hit;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // the seven-bit slave address: fixed high part, pins below
  function automatic logic addr_match(input logic [PORT_W-1:0]     b,
                                      input logic [ADDR_SEL_W-1:0] sel);
    addr_match = (b[PORT_W-1:PORT_W-ADDR_FIX_W] == ADDR_FIX) &&
                 (b[ADDR_SEL_W:1] == sel);
  endfunction

  function automatic logic [BIT_CNT_W-1:0] cnt_inc(input logic [BIT_CNT_W-1:0] c);
    cnt_inc = c + BIT_ONE;
  endfunction

  // ----------------------------------------------------------------
  // start and stop capture
  // ----------------------------------------------------------------
  // a data edge while the clock is high is a bus condition, never a
  // bit; each condition flips its own toggle so the clock-side logic
  // sees it without a handshake
  always_comb begin
    start_tog_d = scl_clk_i ? ~start_tog_q : start_tog_q;
    stop_tog_d  = scl_clk_i ? ~stop_tog_q  : stop_tog_q;
  end

  always_ff @(negedge sda_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      start_tog_q <= 1'b0;
    end else begin
      start_tog_q <= start_tog_d;
    end
  end

  always_ff @(posedge sda_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stop_tog_q <= 1'b0;
    end else begin
      stop_tog_q <= stop_tog_d;
    end
  end

  // the toggles settle a half clock before the rising edge that reads
  // them, which the bus hold and set-up times guarantee
  assign start_pend = start_tog_q ^ start_seen_q;
  assign stop_pend  = stop_tog_q ^ stop_seen_q;

  // ----------------------------------------------------------------
  // pins and strap inputs into the link domain
  // ----------------------------------------------------------------
  ioexp_sync #(
    .W       (LSYNC_W),
    .RST_VAL ({PORT_RST, 3'h0})
  ) u_lnk_sync (
    .clk_i (scl_clk_i),
    .rst_i (sys_rst_i),
    .d_i   ({port_line_i, addr_select_pin_2_i, addr_select_pin_1_i,
             addr_select_pin_0_i}),
    .q_o   (lnk_sync)
  );

  assign lnk_pins = lnk_sync[LSYNC_W-1:ADDR_SEL_W];
  assign lnk_sel  = lnk_sync[ADDR_SEL_W-1:0];

  // ----------------------------------------------------------------
  // receive group: samples the data line on the rising clock edge
  // ----------------------------------------------------------------
  assign rx_byte  = {shift_q[PORT_W-2:0], sda_i};
  assign addr_hit = addr_match(rx_byte, lnk_sel);

  always_comb begin
    state_d      = state_q;
    shift_d      = shift_q;
    cnt_d        = cnt_q;
    start_seen_d = start_tog_q;
    stop_seen_d  = stop_tog_q;
    wr_commit_d  = wr_commit_q;
    rd_clr_d     = rd_clr_q;
    if (start_pend) begin
      // first address bit rides on the first clock after a start
      state_d = LNK_ADDR;
      shift_d = rx_byte;
      cnt_d   = BIT_ONE;
    end else if (stop_pend) begin
      state_d = LNK_IDLE;
      cnt_d   = BIT_FIRST;
    end else begin
      unique case (state_q)
        LNK_IDLE: begin
          cnt_d = BIT_FIRST;
        end
        LNK_ADDR: begin
          shift_d = rx_byte;
          cnt_d   = cnt_inc(cnt_q);
          if (cnt_q == BIT_LAST) begin
            // another device's address: stay off the bus till a start
            state_d = addr_hit ? LNK_ADDR_ACK : LNK_IDLE;
          end
        end
        LNK_ADDR_ACK: begin
          // direction is the last address bit, high for read
          state_d = shift_q[0] ? LNK_RD_DATA : LNK_WR_DATA;
          cnt_d   = BIT_FIRST;
        end
        LNK_WR_DATA: begin
          shift_d = rx_byte;
          cnt_d   = cnt_inc(cnt_q);
          if (cnt_q == BIT_LAST) begin
            state_d = LNK_WR_ACK;
          end
        end
        LNK_WR_ACK: begin
          // no byte limit: every ack leads back to another byte
          state_d     = LNK_WR_DATA;
          cnt_d       = BIT_FIRST;
          wr_commit_d = ~wr_commit_q;
        end
        LNK_RD_DATA: begin
          cnt_d = cnt_inc(cnt_q);
          if (cnt_q == BIT_LAST) begin
            state_d = LNK_RD_ACK;
          end
        end
        LNK_RD_ACK: begin
          // interrupt re-arms on the rising edge of the read ack
          rd_clr_d = ~rd_clr_q;
          cnt_d    = BIT_FIRST;
          state_d  = sda_i ? LNK_IDLE : LNK_RD_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge scl_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q      <= LNK_IDLE;
      shift_q      <= 8'h00;
      cnt_q        <= BIT_FIRST;
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
      wr_commit_q  <= 1'b0;
      rd_clr_q     <= 1'b0;
    end else begin
      state_q      <= state_d;
      shift_q      <= shift_d;
      cnt_q        <= cnt_d;
      start_seen_q <= start_seen_d;
      stop_seen_q  <= stop_seen_d;
      wr_commit_q  <= wr_commit_d;
      rd_clr_q     <= rd_clr_d;
    end
  end

  // ----------------------------------------------------------------
  // transmit group: changes the data line and port on the falling edge
  // ----------------------------------------------------------------
  // driving only while the clock is low keeps the line steady through
  // the whole high phase, acknowledge included
  always_comb begin
    drive_d  = 1'b0;
    tx_d     = tx_q;
    latch_d  = latch_q;
    strong_d = 8'h00;
    wr_clr_d = wr_clr_q;
    unique case (state_q)
      LNK_ADDR_ACK, LNK_WR_ACK: begin
        drive_d = 1'b1;
      end
      LNK_RD_DATA: begin
        // load the pins at the first bit, then shift out msb first
        if (cnt_q == BIT_FIRST) begin
          drive_d = ~lnk_pins[PORT_W-1];
          tx_d    = {lnk_pins[PORT_W-2:0], 1'b0};
        end else begin
          drive_d = ~tx_q[PORT_W-1];
          tx_d    = {tx_q[PORT_W-2:0], 1'b0};
        end
      end
      LNK_IDLE, LNK_ADDR, LNK_WR_DATA, LNK_RD_ACK: begin
        drive_d = 1'b0;
      end
    endcase
    if (wr_commit_q != wr_clr_q) begin
      // first falling edge after a write ack only: a stop and a later
      // start must not repeat the latch, boost and re-arm
      latch_d  = shift_q;
      strong_d = shift_q & ~latch_q;
      wr_clr_d = wr_commit_q;
    end
    // a zero pulls the line low, a one rides on the weak pull-up
    pout_d = latch_d;
    poe_d  = ~latch_d | strong_d;
  end

  always_ff @(negedge scl_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drive_q  <= 1'b0;
      tx_q     <= 8'h00;
      latch_q  <= PORT_RST;
      strong_q <= 8'h00;
      pout_q   <= PORT_RST;
      poe_q    <= 8'h00;
      wr_clr_q <= 1'b0;
    end else begin
      drive_q  <= drive_d;
      tx_q     <= tx_d;
      latch_q  <= latch_d;
      strong_q <= strong_d;
      pout_q   <= pout_d;
      poe_q    <= poe_d;
      wr_clr_q <= wr_clr_d;
    end
  end

  // ----------------------------------------------------------------
  // data line pin
  // ----------------------------------------------------------------
  // a stop releases the line at once, without waiting for a clock
  // that may never come
  assign sda_o    = 1'b0;
  assign sda_oe_o = drive_q & ~stop_pend;

  // ----------------------------------------------------------------
  // port pins
  // ----------------------------------------------------------------
  // strong_q is kept so the boost can be seen in waveforms; the pin
  // enable already carries it
  assign port_line_o    = pout_q;
  assign port_line_oe_o = poe_q | strong_q;

  // ----------------------------------------------------------------
  // crossing into the system clock domain
  // ----------------------------------------------------------------
  // the latch only moves once per written byte, so a plain level
  // synchroniser is enough; a line may glitch the compare for one
  // cycle in the rare case that its latch and pin move together
  always_comb begin
    cross_raw.pins   = port_line_i;
    cross_raw.latch  = latch_q;
    cross_raw.rd_clr = rd_clr_q;
    cross_raw.wr_clr = wr_clr_q;
  end

  ioexp_sync #(
    .W       (CROSS_W),
    .RST_VAL ({PORT_RST, PORT_RST, 2'h0})
  ) u_sys_sync (
    .clk_i (clock_i),
    .rst_i (sys_rst_i),
    .d_i   (cross_raw),
    .q_o   (cross_sync)
  );

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  ioexp_irq u_irq (
    .clock_i    (clock_i),
    .sys_rst_i  (sys_rst_i),
    .pins_i     (cross_sync.pins),
    .latch_i    (cross_sync.latch),
    .clr_tog_i  ({cross_sync.rd_clr, cross_sync.wr_clr}),
    .irq_pend_o (irq_pend)
  );

  // open drain: the pin is pulled low only while a change is pending
  assign irq_n_o    = 1'b0;
  assign irq_n_oe_o = irq_pend;

endmodule // ioexp_top

// ===== verification/ioexp_top_asserts.sv
// concurrent checks on the serial port expander slave
`timescale 1ns/10ps

module ioexp_top_asserts
  import ioexp_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              sys_rst_i,
  input wire logic              scl_clk_i,
  input wire logic              sda_i,
  input wire logic              sda_o,
  input wire logic              sda_oe_o,
  input wire logic              addr_select_pin_0_i,
  input wire logic              addr_select_pin_1_i,
  input wire logic              addr_select_pin_2_i,
  input wire logic [PORT_W-1:0] port_line_i,
  input wire logic [PORT_W-1:0] port_line_o,
  input wire logic [PORT_W-1:0] port_line_oe_o,
  input wire logic              irq_n_o,
  input wire logic              irq_n_oe_o
);
  // ------------------------------------------------------------
  // helper: cycles since the port pins last moved, saturating
  // ------------------------------------------------------------
  logic [3:0]        age_q, age_d;
  logic [PORT_W-1:0] pins_q, pins_d;

  // restart on any movement of the pins
  always_comb begin
    pins_d = port_line_i;
    age_d  = (port_line_i != pins_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
  end

  // registers only
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pins_q <= PORT_RST;
      age_q  <= 4'hF;
    end else begin
      pins_q <= pins_d;
      age_q  <= age_d;
    end
  end

  // ------------------------------------------------------------
  // bus conditions, seen only when the clock stays high across two samples
  // ------------------------------------------------------------
  sequence s_start;
    scl_clk_i && $past(scl_clk_i) && $fell(sda_i);
  endsequence
  sequence s_stop;
    scl_clk_i && $past(scl_clk_i) && $rose(sda_i);
  endsequence

  property p_rst_vals;
    @(posedge clock_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> port_line_o == PORT_RST && port_line_oe_o == 8'h00 && !irq_n_oe_o;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("port state wrong after reset");

  property p_open_drain;
    @(posedge clock_i) disable iff (sys_rst_i) sda_o == 1'b0 && irq_n_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain level not low");

  property p_low_driven;
    @(posedge scl_clk_i) disable iff (sys_rst_i) (~port_line_o & ~port_line_oe_o) == 8'h00;
  endproperty
  a_low_driven: assert property (p_low_driven) else $error("latched zero not driven");

  property p_spu_short;
    @(negedge scl_clk_i) disable iff (sys_rst_i)
    (port_line_o & port_line_oe_o) != 8'h00 |=> (port_line_o & port_line_oe_o) == 8'h00;
  endproperty
  a_spu_short: assert property (p_spu_short) else $error("strong pull-up too long");

  property p_sda_low_phase;
    @(posedge clock_i) disable iff (sys_rst_i) $changed(sda_oe_o) |-> !scl_clk_i;
  endproperty
  a_sda_low_phase: assert property (p_sda_low_phase) else $error("data moved, clock high");

  property p_irq_cause;
    @(posedge clock_i) disable iff (sys_rst_i) $rose(irq_n_oe_o) |-> age_q <= 4'h8;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without pin edge");

  property p_stop_rel;
    @(posedge clock_i) disable iff (sys_rst_i) s_stop |=> !sda_oe_o [*4];
  endproperty
  a_stop_rel: assert property (p_stop_rel) else $error("data held after stop");

  property p_start_quiet;
    @(posedge clock_i) disable iff (sys_rst_i) s_start |=> !sda_oe_o [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("drive during address");

endmodule // ioexp_top_asserts

bind ioexp_top ioexp_top_asserts u_chk (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .scl_clk_i(scl_clk_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_select_pin_0_i(addr_select_pin_0_i),
  .addr_select_pin_1_i(addr_select_pin_1_i), .addr_select_pin_2_i(addr_select_pin_2_i),
  .port_line_i(port_line_i), .port_line_o(port_line_o), .port_line_oe_o(port_line_oe_o),
  .irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o)
);

// ===== verification/ioexp_master.sv
// behavioural two-wire bus master for the expander's serial link
`timescale 1ns/10ps

module ioexp_master (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  // idle: both lines released, clock stands still high
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // one bit of 48 ns: 30 low, 18 high, so a low phase outlasts a system cycle
  task automatic bit_io(input logic b, output logic s);
    #15 sda_low_o = !b;
    #15 scl_o = 1'b1;
    #9 s = sda_i;
    #9 scl_o = 1'b0;
  endtask

  // called only on an idle bus
  task automatic start();
    #30 sda_low_o = 1'b1;
    #30 scl_o = 1'b0;
  endtask

  // data rises while clock high, then both rest high
  task automatic stop();
    #15 sda_low_o = 1'b1;
    #15 scl_o = 1'b1;
    #15 sda_low_o = 1'b0;
    #30;
  endtask

  // eight bits msb first, then a released acknowledge slot
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask

  // no acknowledge marks the last wanted byte
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(!ack, s);
  endtask
endmodule // ioexp_master

// ===== verification/ioexp_top_tb.sv
// self-checking bench for the serial port expander slave
`timescale 1ns/10ps

module ioexp_top_tb;
  import ioexp_pkg::*;

  logic              clock_i, sys_rst_i, scl, sda_low, sda_w, sda_oe, irq_n_oe, irq_line;
  logic [2:0]        sel;
  logic [PORT_W-1:0] ext_low, pins, p_out, p_oe;
  int                fail_count, num_checks;

  // wire levels: pull-ups win unless someone pulls low
  assign sda_w    = !(sda_low || sda_oe);
  assign irq_line = !irq_n_oe;
  assign pins     = (p_oe & p_out) | (~p_oe & ~ext_low);

  ioexp_top DUT (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .scl_clk_i(scl), .sda_i(sda_w),
    .sda_o(), .sda_oe_o(sda_oe), .addr_select_pin_0_i(sel[0]),
    .addr_select_pin_1_i(sel[1]), .addr_select_pin_2_i(sel[2]),
    .port_line_i(pins), .port_line_o(p_out), .port_line_oe_o(p_oe),
    .irq_n_o(), .irq_n_oe_o(irq_n_oe)
  );
  ioexp_master u_mst (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));

  // system clock, 25 ns
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic frame(input logic [7:0] ab, output logic ack);
    u_mst.start();
    u_mst.wr_byte(ab, ack);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk(p_out, PORT_RST, "latch at reset");
    chk(p_oe, 8'h00, "strong drive at reset");
    chk({6'h0, sda_oe, irq_n_oe}, 8'h00, "idle drive");
  endtask

  // two bytes in one frame; 0->1 bits get one clock of strong pull-up
  task automatic t_write();
    logic a;
    frame({ADDR_FIX_DEF, sel, 1'b0}, a);
    chk({7'h0, a}, 8'h01, "write address ack");
    u_mst.wr_byte(8'h5A, a);
    @(negedge clock_i);
    chk({7'h0, a}, 8'h01, "data ack");
    chk(p_out, 8'h5A, "latch");
    chk(p_oe, 8'hA5, "drive");
    u_mst.wr_byte(8'hC3, a);
    @(negedge clock_i);
    chk(p_out, 8'hC3, "second byte");
    chk(p_oe, 8'hBD, "pull-up pulse");
    u_mst.stop();
    chk(p_out, 8'hC3, "held after stop");
    frame({ADDR_FIX_DEF, sel, 1'b0}, a);
    chk(p_oe, 8'h3C, "pulse ended");
    u_mst.wr_byte(PORT_RST, a);
    u_mst.stop();
  endtask

  // every select value: own address taken, neighbour refused
  task automatic t_sel();
    logic a;
    for (int k = 0; k < 8; k++) begin
      @(negedge clock_i);
      sel = k[2:0];
      frame({ADDR_FIX_DEF, k[2:0], 1'b0}, a);
      u_mst.stop();
      chk({7'h0, a}, 8'h01, "own address");
      frame({ADDR_FIX_DEF, k[2:0] ^ 3'h1, 1'b0}, a);
      u_mst.stop();
      chk({7'h0, a}, 8'h00, "foreign select");
    end
    frame({~ADDR_FIX_DEF, sel, 1'b0}, a);
    u_mst.stop();
    chk({7'h0, a}, 8'h00, "foreign upper bits");
  endtask

  task automatic t_read();
    logic       a;
    logic [7:0] d;
    @(negedge clock_i);
    ext_low = 8'hA1;
    frame({ADDR_FIX_DEF, sel, 1'b1}, a);
    chk({7'h0, a}, 8'h01, "read address ack");
    u_mst.rd_byte(1'b1, d);
    chk(d, 8'h5E, "first read");
    u_mst.rd_byte(1'b0, d);
    chk(d, 8'h5E, "last read");
    @(negedge clock_i);
    chk({7'h0, sda_oe}, 8'h00, "released after nack");
    u_mst.stop();
  endtask

  // read left the pulled state as reference, so release is an edge
  task automatic t_irq();
    logic a;
    @(negedge clock_i);
    ext_low = 8'h00;
    repeat (8) @(negedge clock_i);
    chk({7'h0, irq_n_oe}, 8'h01, "edge after read");
    frame({ADDR_FIX_DEF, sel, 1'b0}, a);
    u_mst.wr_byte(PORT_RST, a);
    u_mst.stop();
    repeat (8) @(negedge clock_i);
    chk({7'h0, irq_n_oe}, 8'h00, "cleared by write");
    ext_low = 8'h08;
    repeat (8) @(negedge clock_i);
    chk({7'h0, irq_line}, 8'h00, "line low on change");
    // another device's frame must leave a pending interrupt alone
    frame({~ADDR_FIX_DEF, sel, 1'b0}, a);
    u_mst.stop();
    repeat (8) @(negedge clock_i);
    chk({7'h0, irq_n_oe}, 8'h01, "kept over other device");
    ext_low = 8'h00;
    repeat (8) @(negedge clock_i);
    chk({7'h0, irq_n_oe}, 8'h00, "cleared on restore");
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    sys_rst_i  = 1'b1;
    sel        = 3'h5;
    ext_low    = 8'h00;
    fail_count = 0;
    num_checks = 0;
    repeat (20) @(posedge clock_i);
    @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clock_i);
    t_reset();
    t_write();
    t_sel();
    t_read();
    t_irq();
    final_report();
  end

  // run needs about 20 us; a hang stops at 100 us
  initial begin
    #100000;
    fail_count++;
    $display("unexpected at %0t ns: run timed out", $time);
    final_report();
  end
endmodule // ioexp_top_tb
